// File: iogb_buf_model.sv
// Output buffer model of one cell pair, pulled up when released
`timescale 1ns/1ns
module iogb_buf_model (
  input wire [1:0] pad_data_in, // Data from the paths
  input wire [1:0] tristate_ctl_n_in, // Low while a path drives
  output wire [1:0] pad_out // Level back to the paths
);
  // buffer loop back; the lag keeps a pad that moves on the clock edge
  // from racing the flops that sample it
  assign #1 pad_out = (~tristate_ctl_n_in & pad_data_in) | tristate_ctl_n_in;
endmodule

// File: iogb_map.vh
// Constants for the I/O output register gearbox block
`ifndef IOGB_MAP_VH
`define IOGB_MAP_VH

// Register byte offsets
`define IOGB_REG_CTRL 4'h0
`define IOGB_REG_STATUS 4'h4
`define IOGB_REG_CONFIG 4'h8

// Control register fields
`define IOGB_CTRL_RUN_BIT 0
`define IOGB_CTRL_OE_BIT 1
`define IOGB_CTRL_RESET 2'h0
`define IOGB_CTRL_W 2

// Status register fields
`define IOGB_STAT_LEVEL_LSB 0
`define IOGB_STAT_LEVEL_W 4
`define IOGB_STAT_SEL_LSB 4
`define IOGB_STAT_EMPTY_BIT 6
`define IOGB_STAT_FULL_BIT 7

// Config register fields
`define IOGB_CFG_MODE_LSB 0
`define IOGB_CFG_LATCH_LSB 4

// Output modes, two bits per path
`define IOGB_MODE_SDR 2'h0
`define IOGB_MODE_DDR 2'h1
`define IOGB_MODE_GEAR 2'h2

// Edge of the die where a path sits
`define IOGB_EDGE_SIDE 2'h0
`define IOGB_EDGE_TOP 2'h1
`define IOGB_EDGE_BOTTOM 2'h2

// Per path FIFO word: drive flag and four streams
`define IOGB_PATHS 2
`define IOGB_SLICE_W 5
`define IOGB_BIT_DRIVE 4
`define IOGB_BIT_POS_A 3
`define IOGB_BIT_NEG_A 2
`define IOGB_BIT_POS_B 1
`define IOGB_BIT_NEG_B 0

// FIFO sizing
`define IOGB_FIFO_DEPTH 8
`define IOGB_FIFO_AW 3

`endif

// File: iogb_top.v
// I/O cell pair output register path with SDR, DDR and gearbox modes
//
// Contract
// - Cell pair holds two independent buffered paths; here both share one FIFO word and one slot select, so they move in step
// - Path drives data, tristate; returns buffer input
// - SDR: positive phase A feeds one element
// - SDR element is flip-flop or latch
// - DDR: capture two inputs on rising edge
// - DDR: one value held second half-period
// - Clock-driven mux alternates 11 and 01
// - Gearbox: register four streams on rising edge
// - Gearbox: two streams also held stable
// - Gearbox mux steered by two edge clocks
// - Edge clocks come from strobe write logic
// - Side edges: SDR, DDR and gearbox
// - Top edge: as sides, no gearbox
// - Bottom edge: SDR registers only
`timescale 1ns/1ns
`include "iogb_map.vh"

// Word buffer between the core stream and the path registers
module iogb_fifo #(
  parameter W = 10,
  parameter DEPTH = `IOGB_FIFO_DEPTH,
  parameter AW = `IOGB_FIFO_AW
) (
  input wire clk_in, // System clock
  input wire rst_n_in, // Async reset, active low
  input wire in_valid_in, // Write side valid
  output wire in_ready_out, // Write side ready
  input wire [W-1:0] in_data_in, // Write data
  output wire out_valid_out, // Read side valid
  input wire out_ready_in, // Read side ready
  output wire [W-1:0] out_data_out, // Head word
  output wire [AW:0] level_out // Words held
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  reg [AW-1:0] wr_ptr_d;
  reg [AW-1:0] rd_ptr_d;
  reg [AW:0] count_d;
  wire push;
  wire pop;

  // Explicit wrap point, so a depth short of the pointer range works too
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];
  localparam [AW-1:0] LAST_PTR = DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};

  assign in_ready_out = (count_q != FULL_CNT);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem[rd_ptr_q];
  assign level_out = count_q;

  // Storage has no reset; only words below the count are ever read
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_in;
    end
  end

  always @* begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    if (push) begin
      wr_ptr_d = (wr_ptr_q == LAST_PTR) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == LAST_PTR) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
    end
    // Push and pop together leave the level unchanged
    if (push & ~pop) begin
      count_d = count_q + 1'b1;
    end else if (pop & ~push) begin
      count_d = count_q - 1'b1;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end
endmodule

// Two output paths sharing one FIFO, one slot select and a register port
module iogb_top #(
  parameter [3:0] PATH_MODES = {`IOGB_MODE_GEAR, `IOGB_MODE_DDR},
  parameter [3:0] PATH_EDGES = {`IOGB_EDGE_SIDE, `IOGB_EDGE_SIDE},
  parameter [1:0] SDR_LATCH = 2'h0
) (
  input wire core_clk_in, // System clock, 50 MHz
  input wire rst_n_in, // Async reset, active low
  input wire [3:0] reg_addr_in, // Register byte address
  input wire [31:0] reg_wdata_in, // Register write data
  input wire reg_wr_in, // Register write strobe
  input wire reg_rd_in, // Register read strobe
  output reg [31:0] reg_rdata_out, // Read data, cycle after strobe
  input wire core_valid_in, // Core word valid
  output wire core_ready_out, // Core word accepted
  input wire [7:0] core_data_in, // Four streams per path
  input wire [1:0] core_drive_in, // Per path drive request
  input wire edge_strobe_clk_0_in, // Edge clock 0 from strobe logic
  input wire edge_strobe_clk_1_in, // Edge clock 1 from strobe logic
  output wire [1:0] pad_data_out, // Data to output buffers
  output wire [1:0] tristate_ctl_n_out, // Buffer enable, low drives
  input wire [1:0] pad_in, // Value from input buffers
  output wire [1:0] pad_rx_out // Synchronised buffer value
);
  localparam FW = `IOGB_PATHS * `IOGB_SLICE_W;
  localparam AW = `IOGB_FIFO_AW;

  reg [1:0] ctrl_q;
  reg [1:0] esc_meta_q;
  reg [1:0] esc_sync_q;
  reg [1:0] rx_meta_q;
  reg [1:0] rx_sync_q;
  wire [FW-1:0] fifo_in;
  wire [FW-1:0] head;
  wire head_valid;
  wire pop;
  wire [AW:0] level;
  wire [1:0] sel;
  wire [3:0] eff_modes;
  reg [31:0] rdata_d;
  wire ctrl_wr;

  // Drain only while running; stopping lets the FIFO fill and stall the core
  assign pop = head_valid & ctrl_q[`IOGB_CTRL_RUN_BIT];

  // Only CTRL takes writes; writes elsewhere fall away silently
  assign ctrl_wr = reg_wr_in & (reg_addr_in == `IOGB_REG_CTRL);

  // One FIFO word carries both paths, so the two stay in step

  iogb_fifo #(
    .W(FW),
    .DEPTH(`IOGB_FIFO_DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(core_valid_in),
    .in_ready_out(core_ready_out),
    .in_data_in(fifo_in),
    .out_valid_out(head_valid),
    .out_ready_in(ctrl_q[`IOGB_CTRL_RUN_BIT]),
    .out_data_out(head),
    .level_out(level)
  );

  // Edge clocks arrive from outside, synchronised first
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      esc_meta_q <= 2'h0;
      esc_sync_q <= 2'h0;
    end else begin
      esc_meta_q <= {edge_strobe_clk_1_in, edge_strobe_clk_0_in};
      esc_sync_q <= esc_meta_q;
    end
  end
  // Bits cross apart: move one pin at a time or a stray slot may show
  assign sel = esc_sync_q;

  // Buffer input returned to the core
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_meta_q <= 2'h0;
      rx_sync_q <= 2'h0;
    end else begin
      rx_meta_q <= pad_in;
      rx_sync_q <= rx_meta_q;
    end
  end
  assign pad_rx_out = rx_sync_q;

  genvar i;
  generate
    for (i = 0; i < `IOGB_PATHS; i = i + 1) begin : g_io_path
      localparam [1:0] REQ = PATH_MODES[2*i+1:2*i];
      localparam [1:0] EDGE = PATH_EDGES[2*i+1:2*i];
      // Side edges keep any requested mode
      // Top edge falls back from gearbox to DDR
      // Bottom edge is forced to SDR
      localparam [1:0] MODE = (EDGE == `IOGB_EDGE_BOTTOM) ?
        `IOGB_MODE_SDR :
        ((EDGE == `IOGB_EDGE_TOP) && (REQ == `IOGB_MODE_GEAR)) ?
        `IOGB_MODE_DDR : REQ;
      localparam B = i * `IOGB_SLICE_W;
      wire [4:0] word;
      reg pa_q;
      reg na_q;
      reg pb_q;
      reg nb_q;
      reg drv_q;
      reg na_hold_q;
      reg nb_hold_q;
      reg gear_q;
      reg gear_d;
      reg pad_sel;
      reg sdr_lat_q;
      wire pa_d;
      wire sdr_out;
      wire ddr_out;

      assign fifo_in[B+`IOGB_SLICE_W-1:B] =
        {core_drive_in[i], core_data_in[4*i+3:4*i]};
      assign word = head[B+`IOGB_SLICE_W-1:B];
      assign eff_modes[2*i+1:2*i] = MODE;
      assign pa_d = pop ? word[`IOGB_BIT_POS_A] : pa_q;

      // Rising edge capture of the streams
      always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pa_q <= 1'b0;
          na_q <= 1'b0;
          pb_q <= 1'b0;
          nb_q <= 1'b0;
          drv_q <= 1'b0;
        end else begin
          pa_q <= pa_d;
          if (pop) begin
            na_q <= word[`IOGB_BIT_NEG_A];
            pb_q <= word[`IOGB_BIT_POS_B];
            nb_q <= word[`IOGB_BIT_NEG_B];
            drv_q <= word[`IOGB_BIT_DRIVE];
          end
        end
      end

      // Negative phase held for the low half
      always @(negedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          na_hold_q <= 1'b0;
          nb_hold_q <= 1'b0;
        end else begin
          na_hold_q <= na_q;
          nb_hold_q <= nb_q;
        end
      end

      // Not reset: it follows pa_d, which reset holds at zero
      // Transparent while clock high when latch chosen
      always @(core_clk_in or pa_d) begin
        if (core_clk_in) begin
          sdr_lat_q <= pa_d;
        end
      end

      // Positive phase A alone drives the pad
      assign sdr_out = SDR_LATCH[i] ? sdr_lat_q : pa_q;

      // Combinational by nature: the pad toggles with the clock itself
      // Clock high selects 11, low selects 01
      assign ddr_out = core_clk_in ? pa_q : na_hold_q;

      // Edge clock pair picks the slot
      always @* begin
        case (sel)
          2'h0: gear_d = pa_q;
          2'h1: gear_d = na_hold_q;
          2'h2: gear_d = pb_q;
          2'h3: gear_d = nb_hold_q;
          default: gear_d = 1'b0;
        endcase
      end

      always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          gear_q <= 1'b0;
        end else begin
          gear_q <= gear_d;
        end
      end

      // Mode fixed at elaboration per path
      always @* begin
        case (MODE)
          `IOGB_MODE_GEAR: pad_sel = gear_q;
          `IOGB_MODE_DDR: pad_sel = ddr_out;
          default: pad_sel = sdr_out;
        endcase
      end
      assign pad_data_out[i] = pad_sel;

      // Enable low while the path drives
      assign tristate_ctl_n_out[i] =
        ~(drv_q & ctrl_q[`IOGB_CTRL_OE_BIT]);
    end
  endgenerate

  always @* begin
    rdata_d = 32'h0;
    case (reg_addr_in)
      `IOGB_REG_CTRL: rdata_d[`IOGB_CTRL_W-1:0] = ctrl_q;
      `IOGB_REG_STATUS: begin
        rdata_d[`IOGB_STAT_LEVEL_LSB+AW:`IOGB_STAT_LEVEL_LSB] = level;
        rdata_d[`IOGB_STAT_SEL_LSB+1:`IOGB_STAT_SEL_LSB] = sel;
        rdata_d[`IOGB_STAT_EMPTY_BIT] = ~head_valid;
        rdata_d[`IOGB_STAT_FULL_BIT] = ~core_ready_out;
      end
      `IOGB_REG_CONFIG: begin
        rdata_d[`IOGB_CFG_MODE_LSB+3:`IOGB_CFG_MODE_LSB] = eff_modes;
        rdata_d[`IOGB_CFG_LATCH_LSB+1:`IOGB_CFG_LATCH_LSB] = SDR_LATCH;
      end
      default: rdata_d = 32'h0;
    endcase
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= `IOGB_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata_in[`IOGB_CTRL_W-1:0];
    end
  end

  // Unmapped reads return zero; the port idles at zero between replies
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= 32'h0;
    end
  end
endmodule

// File: iogb_top_monitor.sv
// Port level assertions for the gearbox top
`timescale 1ns/1ns
module iogb_top_monitor #(
  parameter [1:0] SDR_LATCH = 2'h0
) (
  input wire core_clk_in, // System clock
  input wire rst_n_in, // Reset, active low
  input wire [3:0] reg_addr_in, // Register address
  input wire reg_rd_in, // Read strobe
  input wire [31:0] reg_rdata_out, // Read data
  input wire core_ready_out, // FIFO not full
  input wire [1:0] pad_in, // Buffer value
  input wire [1:0] pad_rx_out // Synchronised value
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  reg [1:0] up_q;
  // Pad history is meaningless until two edges after reset
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  end
  sequence s_st; reg_rd_in && reg_addr_in == 4'h4 ##1 1'b1; endsequence
  sequence s_cf; reg_rd_in && reg_addr_in == 4'h8 ##1 1'b1; endsequence
  property p_rx; up_q == 2'h3 |-> pad_rx_out == $past(pad_in, 2); endproperty
  a_rx: assert property (p_rx) else $error("rx lag");
  property p_idle; !$past(reg_rd_in) |-> reg_rdata_out == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_bad; reg_rd_in && reg_addr_in == 4'hC |=> reg_rdata_out == 0;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped read");
  property p_full; s_st |-> reg_rdata_out[7] == !$past(core_ready_out);
  endproperty
  a_full: assert property (p_full) else $error("full flag");
  property p_emp; s_st |-> reg_rdata_out[6] == (reg_rdata_out[3:0] == 0);
  endproperty
  a_emp: assert property (p_emp) else $error("empty flag");
  property p_lvl; s_st |-> reg_rdata_out[3:0] <= 4'h8; endproperty
  a_lvl: assert property (p_lvl) else $error("level range");
  property p_lf; s_st |-> reg_rdata_out[7] == (reg_rdata_out[3:0] == 8);
  endproperty
  a_lf: assert property (p_lf) else $error("full vs level");
  property p_cfg; s_cf |-> reg_rdata_out[5:4] == SDR_LATCH; endproperty
  a_cfg: assert property (p_cfg) else $error("config latch");
endmodule
bind iogb_top iogb_top_monitor #(.SDR_LATCH(SDR_LATCH)) mon (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .core_ready_out(core_ready_out), .pad_in(pad_in), .pad_rx_out(pad_rx_out));

// File: tb.sv
// Self-checking bench for the output register gearbox
`timescale 1ns/1ns
module tb;
  reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, vld = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wd = 32'h0;
  reg [7:0] dat = 8'h00, w;
  reg [1:0] drv = 2'h0, edg = 2'h0, v;
  wire [31:0] rdat, rdat2;
  wire rdy;
  wire [1:0] pad, pad2, tri_n, pin, rx;
  integer n_mismatch = 0, check_count = 0, i, j, s, n_acc = 0;
  always #10 clk = ~clk;
  iogb_top uut (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
    .core_valid_in(vld), .core_ready_out(rdy), .core_data_in(dat),
    .core_drive_in(drv), .edge_strobe_clk_0_in(edg[0]),
    .edge_strobe_clk_1_in(edg[1]), .pad_data_out(pad),
    .tristate_ctl_n_out(tri_n), .pad_in(pin), .pad_rx_out(rx));
  // Path 1 on the top edge, path 0 on the bottom edge as a latch
  iogb_top #(.PATH_EDGES(4'h6), .SDR_LATCH(2'h1)) uut2 (.core_clk_in(clk),
    .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdat2), .core_valid_in(vld), .core_ready_out(),
    .core_data_in(dat), .core_drive_in(drv), .edge_strobe_clk_0_in(edg[0]),
    .edge_strobe_clk_1_in(edg[1]), .pad_data_out(pad2),
    .tristate_ctl_n_out(), .pad_in(pin), .pad_rx_out());
  iogb_buf_model bufm (.pad_data_in(pad), .tristate_ctl_n_in(tri_n),
    .pad_out(pin));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdat & m, e);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(4'h0, 32'h3, 32'h0);
    rd_reg(4'h8, 32'h3F, 32'h09);
    chk(rdat2[5:0], 6'h14);
    wr_reg(4'h4, 32'hFF);
    rd_reg(4'h4, 32'hCF, 32'h40);
    rd_reg(4'hC, 32'hFFFFFFFF, 32'h0);
    $display("test registers done");
    // Drain is off, so the FIFO must refuse after eight words
    @(posedge clk);
    vld <= 1'b1;
    for (i = 0; i < 12; i = i + 1) begin
      @(negedge clk);
      if (rdy === 1'b1)
        n_acc = n_acc + 1;
    end
    @(posedge clk);
    vld <= 1'b0;
    chk(n_acc, 8);
    rd_reg(4'h4, 32'hCF, 32'h88);
    wr_reg(4'h0, 32'h3);
    repeat (12) @(posedge clk);
    rd_reg(4'h4, 32'hCF, 32'h40);
    $display("test fifo done");
    for (j = 0; j < 2; j = j + 1) begin
      w = j ? 8'h5A : 8'hA5;
      v = j ? 2'h2 : 2'h1;
      @(posedge clk);
      dat <= w;
      drv <= v;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      #5 chk(pad2[0], w[3]);
      repeat (4) @(posedge clk);
      #1 chk(tri_n, {~v});
      @(posedge clk);
      #5 chk(pad[0], w[3]);
      chk(pad2[1], w[7]);
      @(negedge clk);
      #5 chk(pad[0], w[2]);
      chk(pad2[1], w[6]);
      chk(pad2[0], w[3]);
      if (!v[0])
        chk(rx[0], 1);
      for (s = 0; s < 4; s = s + 1) begin
        @(posedge clk);
        edg <= s[1:0];
        repeat (5) @(posedge clk);
        #1 chk(pad[1], w[7 - s]);
        chk(rx[1], v[1] ? w[7 - s] : 1'b1);
      end
      $display("test pads %0d done", j);
    end
    end_sim;
  end
endmodule
